/* verilog/ccru_pkg.sv */
package ccru_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IMM_W = 16;
	localparam int unsigned CLZ_W = 6;
	localparam int unsigned FIELD_SEL_W = 3;
	localparam int unsigned CR_FIELDS = 8;
	// Flag positions inside one 4-bit condition field (bit 3 is leftmost)
	localparam int unsigned LT_POS = 3;
	localparam int unsigned GT_POS = 2;
	localparam int unsigned EQ_POS = 1;
	localparam int unsigned SO_POS = 0;
	localparam logic [31:0] CR_RESET = 32'h0000_0000;
	localparam logic [31:0] GPR_RESET = 32'h0000_0000;
	localparam logic [2:0] FIRST_FIELD = 3'h0;

	typedef enum logic [2:0] {
		CCRU_OP_CLZ = 3'b000,
		CCRU_OP_CMP_SREG = 3'b001,
		CCRU_OP_CMP_SIGNED_IMMEDIATE = 3'b010,
		CCRU_OP_CMP_UREG = 3'b011,
		CCRU_OP_CMP_UNSIGNED_IMMEDIATE = 3'b100,
		CCRU_OP_ROTATE = 3'b101
	} ccru_op_e;

	typedef struct packed {
		logic valid;
		ccru_op_e op;
		logic [31:0] source_reg;
		logic [31:0] first_operand_reg;
		logic [31:0] second_operand_reg;
		logic [15:0] immediate;
		logic [2:0] cond_field_select;
		logic record_flag;
		logic operand_length;
		logic [4:0] rot_amount;
		logic [4:0] mask_begin;
		logic [4:0] mask_end;
	} ccru_req_s;
endpackage : ccru_pkg

/* verilog/ccru_clz.sv */
`timescale 1ns/10ps
`default_nettype none
module ccru_clz #(
	parameter int unsigned W = 32
) (
	input wire logic [W-1:0] value,
	output logic [$clog2(W):0] count
);
	always_comb begin
		count = ($clog2(W) + 1)'(W);
		// Scan from lsb so the highest set bit wins last
		for (int i = 0; i < W; i++) begin
			if (value[i]) begin
				count = ($clog2(W) + 1)'(W - 1 - i);
			end
		end
	end
endmodule : ccru_clz
`default_nettype wire

/* verilog/ccru_rotmask.sv */
`timescale 1ns/10ps
`default_nettype none
module ccru_rotmask (
	input wire logic [31:0] data,
	input wire logic [4:0] amount,
	input wire logic [4:0] mask_begin,
	input wire logic [4:0] mask_end,
	output logic [31:0] result
);
	logic [31:0] rotated;
	logic [31:0] mask;
	logic [63:0] doubled;

	always_comb begin
		doubled = {data, data} << amount;
		rotated = doubled[63:32];
		mask = 32'h0000_0000;
		// Bit index p here is big-endian: p=0 is the msb
		for (int p = 0; p < 32; p++) begin
			if (mask_begin <= mask_end) begin
				mask[31 - p] = (5'(p) >= mask_begin) && (5'(p) <= mask_end);
			end else begin
				mask[31 - p] = (5'(p) >= mask_begin) || (5'(p) <= mask_end);
			end
		end
		result = rotated & mask;
	end
endmodule : ccru_rotmask
`default_nettype wire

/* verilog/ccru_unit.sv */
// What this block does
// - Count leading zeros of source from the msb and write the count.
// - Recorded count updates first field with less-than forced to zero.
// - Compare writes less/greater/equal into the selected condition field.
// - Compare copies summary-overflow into the selected field's lowest bit.
// - Signed compares treat operands as two's complement.
// - Signed immediate is sign-extended to 32 bits.
// - Unsigned compares treat operands as unsigned.
// - Unsigned immediate is zero-extended to 32 bits.
// - Four compare variants: signed/unsigned, register/immediate.
// - Rotate is left only on 32 bits, msb wraps into lsb.
// - Recorded rotate updates the first condition field, else unchanged.
// - Rotate never touches the fixed-point exception register.
// - Rotate writes destination, reads data from the source register.
// - Mask ones run from begin to end inclusive, wrapping when begin exceeds end.
`timescale 1ns/10ps
`default_nettype none
module ccru_unit (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire ccru_pkg::ccru_req_s REQ,
	input wire logic SUMMARY_OVERFLOW,
	output logic RESULT_VALID,
	output logic RESULT_WRITE,
	output logic [31:0] RESULT_DATA,
	output logic [31:0] CONDITION_REGISTER,
	output logic LENGTH_ERROR
);
	logic [5:0] clz_count;
	logic [31:0] rot_result;
	logic [31:0] cmp_b;
	logic signed_cmp;
	logic lt;
	logic gt;
	logic eq;
	logic [3:0] rec_field;
	logic [3:0] cmp_field;
	logic [31:0] wr_data;
	logic rec_en;

	logic valid_q;
	logic valid_d;
	logic write_q;
	logic write_d;
	logic [31:0] data_q;
	logic [31:0] data_d;
	logic [31:0] cr_q;
	logic [31:0] cr_d;
	logic lerr_q;
	logic lerr_d;

	ccru_clz #(
		.W(ccru_pkg::DATA_W)
	) u_clz (
		.value(REQ.source_reg),
		.count(clz_count)
	);

	ccru_rotmask u_rot (
		.data(REQ.source_reg),
		.amount(REQ.rot_amount),
		.mask_begin(REQ.mask_begin),
		.mask_end(REQ.mask_end),
		.result(rot_result)
	);

	always_comb begin
		signed_cmp = (REQ.op == ccru_pkg::CCRU_OP_CMP_SREG) ||
			(REQ.op == ccru_pkg::CCRU_OP_CMP_SIGNED_IMMEDIATE);
		case (REQ.op)
			ccru_pkg::CCRU_OP_CMP_SIGNED_IMMEDIATE: begin
				cmp_b = {{16{REQ.immediate[15]}}, REQ.immediate};
			end
			ccru_pkg::CCRU_OP_CMP_UNSIGNED_IMMEDIATE: begin
				cmp_b = {16'h0000, REQ.immediate};
			end
			default: begin
				cmp_b = REQ.second_operand_reg;
			end
		endcase
		eq = (REQ.first_operand_reg == cmp_b);
		if (signed_cmp) begin
			lt = $signed(REQ.first_operand_reg) < $signed(cmp_b);
			gt = $signed(REQ.first_operand_reg) > $signed(cmp_b);
		end else begin
			lt = REQ.first_operand_reg < cmp_b;
			gt = REQ.first_operand_reg > cmp_b;
		end
		cmp_field = {lt, gt, eq, SUMMARY_OVERFLOW};

		if (REQ.op == ccru_pkg::CCRU_OP_CLZ) begin
			wr_data = {26'h0, clz_count};
		end else begin
			wr_data = rot_result;
		end
		// Record flags from signed view of the written result
		rec_field[ccru_pkg::LT_POS] = wr_data[31];
		rec_field[ccru_pkg::GT_POS] = ~wr_data[31] && (wr_data != 32'h0000_0000);
		rec_field[ccru_pkg::EQ_POS] = (wr_data == 32'h0000_0000);
		rec_field[ccru_pkg::SO_POS] = SUMMARY_OVERFLOW;
		if (REQ.op == ccru_pkg::CCRU_OP_CLZ) begin
			rec_field[ccru_pkg::LT_POS] = 1'b0;
		end
		rec_en = REQ.record_flag && ((REQ.op == ccru_pkg::CCRU_OP_CLZ) ||
			(REQ.op == ccru_pkg::CCRU_OP_ROTATE));
	end

	always_comb begin
		valid_d = REQ.valid;
		write_d = 1'b0;
		data_d = data_q;
		cr_d = cr_q;
		lerr_d = 1'b0;
		if (REQ.valid) begin
			case (REQ.op)
				ccru_pkg::CCRU_OP_CLZ, ccru_pkg::CCRU_OP_ROTATE: begin
					// Exception register is an input only, so rotate cannot alter it
					write_d = 1'b1;
					data_d = wr_data;
					if (rec_en) begin
						cr_d[31:28] = rec_field;
					end
				end
				ccru_pkg::CCRU_OP_CMP_SREG, ccru_pkg::CCRU_OP_CMP_SIGNED_IMMEDIATE,
				ccru_pkg::CCRU_OP_CMP_UREG, ccru_pkg::CCRU_OP_CMP_UNSIGNED_IMMEDIATE: begin
					// 64-bit length is unsupported; flag it but still compare 32 bits
					lerr_d = REQ.operand_length;
					cr_d[(7 - REQ.cond_field_select) * 4 +: 4] = cmp_field;
				end
				default: begin
					valid_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			valid_q <= 1'b0;
			write_q <= 1'b0;
			data_q <= ccru_pkg::GPR_RESET;
			cr_q <= ccru_pkg::CR_RESET;
			lerr_q <= 1'b0;
		end else begin
			valid_q <= valid_d;
			write_q <= write_d;
			data_q <= data_d;
			cr_q <= cr_d;
			lerr_q <= lerr_d;
		end
	end

	assign RESULT_VALID = valid_q;
	assign RESULT_WRITE = write_q;
	assign RESULT_DATA = data_q;
	assign CONDITION_REGISTER = cr_q;
	assign LENGTH_ERROR = lerr_q;
endmodule : ccru_unit
`default_nettype wire

/* dv/ccru_unit_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module ccru_unit_sva (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire ccru_pkg::ccru_req_s REQ,
	input wire logic SUMMARY_OVERFLOW,
	input wire logic RESULT_VALID,
	input wire logic RESULT_WRITE,
	input wire logic [31:0] RESULT_DATA,
	input wire logic [31:0] CONDITION_REGISTER,
	input wire logic LENGTH_ERROR
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);
	chk_answer_lat: assert property (REQ.valid && REQ.op <= 3'h5 |=> RESULT_VALID)
		else $error("no result after request");
	chk_refused_op: assert property (!(REQ.valid && REQ.op <= 3'h5) |=> !RESULT_VALID)
		else $error("result without request");
	chk_clz_lt: assert property (REQ.valid && REQ.op == 3'h0 && REQ.record_flag
		|=> !CONDITION_REGISTER[31] && RESULT_WRITE)
		else $error("count record left less-than set");
	chk_norec_hold: assert property (REQ.valid && REQ.op inside {3'h0, 3'h5} && !REQ.record_flag
		|=> $stable(CONDITION_REGISTER))
		else $error("condition changed without record");
	chk_so_copy: assert property (REQ.valid && REQ.op inside {[3'h1:3'h4]} |=> CONDITION_REGISTER[
		5'd28 - {$past(REQ.cond_field_select), 2'b00}] == $past(SUMMARY_OVERFLOW))
		else $error("overflow copy wrong");
	chk_clz_zero: assert property (REQ.valid && REQ.op == 3'h0 && REQ.source_reg == 32'h0
		|=> RESULT_DATA == 32'h20)
		else $error("count of zero word wrong");
	chk_len_flag: assert property (REQ.valid && REQ.op inside {[3'h1:3'h4]}
		|=> LENGTH_ERROR == $past(REQ.operand_length))
		else $error("length flag wrong");
	chk_rot_plain: assert property (REQ.valid && REQ.op == 3'h5 && REQ.mask_begin == 5'h0
		&& REQ.mask_end == 5'h1f |=> RESULT_DATA == ({$past(REQ.source_reg),
		$past(REQ.source_reg)} << $past(REQ.rot_amount)) >> 32)
		else $error("plain rotate wrong");
endmodule : ccru_unit_sva
`default_nettype wire

/* dv/ccru_decoder_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ccru_decoder_model (
	input wire logic CLOCK,
	output ccru_pkg::ccru_req_s REQ,
	output logic SUMMARY_OVERFLOW
);
	initial begin
		REQ = '0;
		SUMMARY_OVERFLOW = 1'b0;
	end
	// Rotate amount and mask ride in imm; right rotates arrive as 32-n
	task automatic issue(input logic [2:0] op, input logic [31:0] x, input logic [31:0] y,
		input logic [15:0] imm, input logic [2:0] sel, input logic rec, input logic len,
		input logic so);
		@(negedge CLOCK);
		// Destination operand differs from source so a wrong read shows up
		REQ = {1'b1, op, x, ((op == 3'h0) || (op == 3'h5)) ? ~x : x, y, imm, sel, rec, len,
			imm[4:0], imm[9:5], imm[14:10]};
		SUMMARY_OVERFLOW = so;
	endtask : issue
	// Stale operands scrambled, never held
	task automatic idle();
		@(negedge CLOCK);
		REQ = {1'b0, ~REQ[$bits(REQ)-2:0]};
	endtask : idle
endmodule : ccru_decoder_model
`default_nettype wire

/* dv/tb_clz_compare_rotate_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_clz_compare_rotate_unit;
	typedef struct packed {
		logic [2:0] op;
		logic [31:0] x;
		logic [31:0] y;
		logic [15:0] imm;
		logic [2:0] sel;
		logic rec;
		logic so;
		logic [31:0] d;
		logic [3:0] f;
	} ccru_row_t;
	localparam ccru_row_t ROWS [10] = '{
		'{3'h1, 32'hffffffff, 32'h1, 16'h0, 3'h3, 1'b0, 1'b1, 32'h0, 4'h9},
		'{3'h2, 32'hffffffff, 32'h0, 16'hffff, 3'h2, 1'b0, 1'b0, 32'h0, 4'h2},
		'{3'h3, 32'hffffffff, 32'h1, 16'h0, 3'h7, 1'b0, 1'b0, 32'h0, 4'h4},
		'{3'h4, 32'h0000ffff, 32'h0, 16'hffff, 3'h1, 1'b0, 1'b1, 32'h0, 4'h3},
		'{3'h0, 32'h00010000, 32'h0, 16'h0, 3'h0, 1'b1, 1'b1, 32'hf, 4'h5},
		'{3'h0, 32'h0, 32'h0, 16'h0, 3'h0, 1'b1, 1'b0, 32'h20, 4'h4},
		'{3'h5, 32'h80000001, 32'h0, 16'h7c01, 3'h0, 1'b1, 1'b0, 32'h3, 4'h4},
		'{3'h5, 32'h0000000f, 32'h0, 16'h7c1c, 3'h0, 1'b1, 1'b0, 32'hf0000000, 4'h8},
		'{3'h5, 32'h12345678, 32'h0, 16'h5e10, 3'h0, 1'b0, 1'b1, 32'h00001200, 4'h8},
		'{3'h5, 32'hffffffff, 32'h0, 16'h07c0, 3'h0, 1'b1, 1'b1, 32'hc0000003, 4'h9}
	};
	logic CLOCK = 1'b0;
	logic RST_B;
	ccru_pkg::ccru_req_s REQ;
	logic SO;
	logic RV;
	logic RW;
	logic [31:0] DATA;
	logic [31:0] CR;
	logic LE;
	ccru_row_t r;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	ccru_decoder_model u_src (.CLOCK(CLOCK), .REQ(REQ), .SUMMARY_OVERFLOW(SO));
	ccru_unit u_dut (.CLOCK(CLOCK), .RST_B(RST_B), .REQ(REQ), .SUMMARY_OVERFLOW(SO),
		.RESULT_VALID(RV), .RESULT_WRITE(RW), .RESULT_DATA(DATA), .CONDITION_REGISTER(CR),
		.LENGTH_ERROR(LE));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	always #2 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 500) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		RST_B = 1'b0;
		repeat (2) @(negedge CLOCK);
		check({29'h0, RV, RW, LE}, 32'h0);
		check(CR, 32'h0);
		check(DATA, 32'h0);
		RST_B = 1'b1;
		foreach (ROWS[i]) begin
			r = ROWS[i];
			u_src.issue(r.op, r.x, r.y, r.imm, r.sel, r.rec, 1'b0, r.so);
			u_src.idle();
			check({RV, RW}, {1'b1, r.op == 3'h0 || r.op == 3'h5});
			check(DATA, r.d);
			check((CR >> (5'd28 - {r.sel, 2'b00})) & 32'hf, 32'(r.f));
		end
		// Out-of-range length still compares as 32-bit, but is flagged
		u_src.issue(3'h1, 32'h1, 32'h1, 16'h0, 3'h0, 1'b0, 1'b1, 1'b0);
		u_src.idle();
		check({LE, CR[31:28]}, 32'h12);
		u_src.issue(3'h6, 32'h0, 32'h0, 16'h0, 3'h0, 1'b1, 1'b0, 1'b1);
		u_src.idle();
		check({RV, RW, CR[31:28], DATA}, {6'h2, 32'hc0000003});
		test_done();
	end
endmodule : tb_clz_compare_rotate_unit
bind ccru_unit ccru_unit_sva u_sva (.CLOCK(CLOCK), .RST_B(RST_B), .REQ(REQ),
	.SUMMARY_OVERFLOW(SUMMARY_OVERFLOW), .RESULT_VALID(RESULT_VALID),
	.RESULT_WRITE(RESULT_WRITE), .RESULT_DATA(RESULT_DATA),
	.CONDITION_REGISTER(CONDITION_REGISTER), .LENGTH_ERROR(LENGTH_ERROR));
`default_nettype wire
